/* File: hw/clkgen_pkg.sv */
// constants for the system clock generation block
package clkgen_pkg;

    // ********************************************************
    // register offsets on the control bus
    // ********************************************************
    localparam logic [7:0] AUX_A_PLL_CFG_ADDR = 8'hAB;
    localparam logic [7:0] AUX_A_REF_CFG_ADDR = 8'hAC;
    localparam logic [7:0] AUX_B_PLL_CFG_ADDR = 8'hAD;
    localparam logic [7:0] AUX_B_REF_CFG_ADDR = 8'hAE;
    localparam logic [7:0] CORE_PLL_CFG_ADDR = 8'hBC;
    localparam logic [7:0] CORE_REF_CFG_ADDR = 8'hBD;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // ********************************************************
    // field layout of the pll and reference configure words
    // ********************************************************
    localparam int ODIV_LSB = 11;
    localparam int ODIV_W = 5;
    localparam int NDIV_LSB = 0;
    localparam int NDIV_W = 11;
    localparam int REF_PSAVE_BIT = 15;
    localparam int REF_ROUTE_BIT = 14;
    localparam int REF_OUT_EN_BIT = 13;
    localparam int RDIV_LSB = 0;
    localparam int RDIV_W = 13;

    // ********************************************************
    // clock setup entries (program block 3, entries 2 to 6)
    // ********************************************************
    localparam int NUM_SETUP = 5;
    localparam logic [2:0] SETUP_FIRST = 3'h2;
    localparam logic [2:0] SETUP_LAST = 3'h6;
    localparam int SETUP_SRC_BIT = 15;
    localparam int SETUP_RATIO_W = 15;
    localparam int SETUP_ADC = 0;
    localparam int SETUP_DAC = 1;
    localparam int SETUP_CONV = 2;
    localparam int SETUP_TIMER = 3;
    localparam int SETUP_DSP = 4;

    // ********************************************************
    // frequencies and times
    // ********************************************************
    localparam longint CLK_HZ = 100_000_000;
    localparam longint XTAL_NOM_HZ = 6_144_000;
    localparam longint CORE_NOM_HZ = 24_576_000;
    localparam longint CMP_NOM_HZ = 96_000;
    localparam longint XTAL_MAX_HZ = 12_288_000;
    localparam longint EXT_REF_MAX_HZ = 24_576_000;
    localparam longint TIMER_PERIOD_US = 250;
    // fastest reference edge spacing, rounded down
    localparam int REF_MIN_CYC = int'(CLK_HZ / EXT_REF_MAX_HZ);
    localparam int PER_W = 20;

    // ********************************************************
    // reset values (suit a 6.144 MHz reference)
    // ********************************************************
    localparam logic [RDIV_W-1:0] AUX_RDIV_RST =
        RDIV_W'(XTAL_NOM_HZ / CMP_NOM_HZ);
    localparam logic [NDIV_W-1:0] AUX_NDIV_RST = 11'h100;
    localparam logic [ODIV_W-1:0] AUX_ODIV_RST = 5'h02;
    localparam logic [RDIV_W-1:0] CORE_RDIV_RST = 13'h0001;
    localparam logic [NDIV_W-1:0] CORE_NDIV_RST =
        NDIV_W'(CORE_NOM_HZ / XTAL_NOM_HZ);
    localparam logic [SETUP_RATIO_W-1:0] TIMER_DIV_RST =
        SETUP_RATIO_W'((XTAL_NOM_HZ / 1000) * TIMER_PERIOD_US / 1000);
    localparam logic [DATA_W-1:0] SETUP_ADC_RST = 16'h8C00;
    localparam logic [DATA_W-1:0] SETUP_DAC_RST = 16'h8C00;
    localparam logic [DATA_W-1:0] SETUP_CONV_RST = 16'h8030;
    localparam logic [DATA_W-1:0] SETUP_TIMER_RST =
        {1'b0, TIMER_DIV_RST};
    localparam logic [DATA_W-1:0] SETUP_DSP_RST = 16'h8001;

endpackage

/* File: hw/clock_synth_loop.sv */
// digital synthesis loop: reference divider, dco and output divider
`timescale 1ns/1ps
module clock_synth_loop #(
    parameter int RDIV_W = 13,
    parameter int NDIV_W = 11,
    parameter int ODIV_W = 5,
    parameter int PER_W = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ref_tick,
    input wire logic run,
    input wire logic [RDIV_W-1:0] ref_div,
    input wire logic [NDIV_W-1:0] main_div,
    input wire logic [ODIV_W-1:0] out_div,
    output logic clk_out,
    output logic out_tick,
    output logic locked
);
    logic [RDIV_W-1:0] rcnt_q, rcnt_d;
    logic [PER_W-1:0] pcnt_q, pcnt_d, per_q, per_d;
    logic [PER_W:0] acc_q, acc_d, acc_sum;
    logic [ODIV_W-1:0] ocnt_q, ocnt_d;
    logic out_q, out_d, tick_q, tick_d, lock_q, lock_d;
    logic cmp, dco;

    // ********************************************************
    // next state: compare ticks, period measure, dco, divider
    // ********************************************************
    always_comb begin
        rcnt_d = rcnt_q;
        pcnt_d = pcnt_q + 1'b1;
        per_d = per_q;
        lock_d = lock_q;
        acc_d = acc_q;
        ocnt_d = ocnt_q;
        out_d = out_q;
        tick_d = 1'b0;
        cmp = 1'b0;
        dco = 1'b0;
        acc_sum = acc_q + {(PER_W - NDIV_W)'(0), main_div, 1'b0};
        // reference divider, a ratio of 0 behaves as 1
        if (ref_tick) begin
            if (rcnt_q + 1'b1 >= ref_div) begin
                rcnt_d = '0;
                cmp = 1'b1;
            end else begin
                rcnt_d = rcnt_q + 1'b1;
            end
        end
        // compare period measured in system clocks
        if (cmp) begin
            per_d = pcnt_q + 1'b1;
            pcnt_d = '0;
            lock_d = 1'b1;
        end
        // dco: 2N steps per compare period, one per overflow
        if (lock_q) begin
            if (acc_sum >= {1'b0, per_q}) begin
                acc_d = acc_sum - {1'b0, per_q};
                dco = 1'b1;
            end else begin
                acc_d = acc_sum;
            end
        end
        // output divider toggles the clock every D dco steps
        if (dco) begin
            if (ocnt_q + 1'b1 >= out_div) begin
                ocnt_d = '0;
                out_d = ~out_q;
                tick_d = ~out_q;
            end else begin
                ocnt_d = ocnt_q + 1'b1;
            end
        end
        // powersave holds the loop cleared
        if (!run) begin
            rcnt_d = '0;
            pcnt_d = '0;
            lock_d = 1'b0;
            acc_d = '0;
            ocnt_d = '0;
            out_d = 1'b0;
            tick_d = 1'b0;
        end
    end

    // ********************************************************
    // state registers
    // ********************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rcnt_q <= '0;
            pcnt_q <= '0;
            per_q <= '0;
            lock_q <= 1'b0;
            acc_q <= '0;
            ocnt_q <= '0;
            out_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            rcnt_q <= rcnt_d;
            pcnt_q <= pcnt_d;
            per_q <= per_d;
            lock_q <= lock_d;
            acc_q <= acc_d;
            ocnt_q <= ocnt_d;
            out_q <= out_d;
            tick_q <= tick_d;
        end
    end

    assign clk_out = out_q;
    assign out_tick = tick_q;
    assign locked = lock_q;
endmodule

/* File: hw/system_clock_generation.sv */
// system clock generation: core loop, tick dividers, two aux clocks
//
// Behaviour
// - core clock, nominally 24.576 MHz, made from reference by a loop
// - further ticks divide reference or core clock for converters, dsp
// - in idle, bus requests are answered on the timer tick
// - setup entries 2..6 default for 6.144 MHz, host reprograms them
// - aux pll configure sets output and main dividers per channel
// - aux reference configure sets reference divider and routing
// - each aux generator has its own powersave
// - after reset the aux outputs carry the reference clock
// - variant without synthesisers keeps aux outputs off until enabled
// - reference accepted up to 12.288 MHz crystal, 24.576 MHz external
`timescale 1ns/1ps
module system_clock_generation
    import clkgen_pkg::*;
#(
    parameter bit HAS_RF_SYNTH = 1'b1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic XTAL_IN,
    input wire logic REG_WR,
    input wire logic [clkgen_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [clkgen_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic SETUP_WR,
    input wire logic [2:0] SETUP_SEL,
    input wire logic [clkgen_pkg::DATA_W-1:0] SETUP_DATA,
    input wire logic IDLE_MODE,
    input wire logic BUS_REQ,
    output logic BUS_ACK,
    output logic CORE_CLK_TICK,
    output logic ADC_SAMPLE_TICK,
    output logic DAC_SAMPLE_TICK,
    output logic CONVERT_TICK,
    output logic GENERAL_PURPOSE_TICK_TIMER,
    output logic DSP_TICK,
    output logic AUX_CLOCK_OUT_A,
    output logic AUX_CLOCK_OUT_B,
    output logic [1:0] AUX_LOCKED,
    output logic REF_TOO_FAST,
    output logic [clkgen_pkg::PER_W-1:0] REF_PERIOD,
    output logic REG_ERR
);
    import clkgen_pkg::*;

    // ********************************************************
    // elaboration check
    // ********************************************************
    if (PER_W <= SETUP_RATIO_W || PER_W <= NDIV_W + 1) begin : g_chk
        $error("period counter too narrow");
    end

    logic xtal_q, xtal_d, ref_tick;
    logic [PER_W-1:0] rper_cnt_q, rper_cnt_d, rper_q, rper_d;
    logic fast_q, fast_d;
    logic [DATA_W-1:0] pll_cfg_q [2], pll_cfg_d [2];
    logic [DATA_W-1:0] ref_cfg_q [2], ref_cfg_d [2];
    logic [DATA_W-1:0] core_pll_q, core_pll_d, core_ref_q, core_ref_d;
    logic [DATA_W-1:0] setup_q [NUM_SETUP], setup_d [NUM_SETUP];
    logic err_q, err_d;
    logic core_clk, core_tick, core_lock;
    logic [1:0] aux_clk, aux_lock, aux_run;
    logic [1:0] aux_out_q, aux_out_d;
    logic [1:0] aux_lock_q, aux_lock_d;
    logic [NUM_SETUP-1:0] div_tick_q, div_tick_d;
    logic [SETUP_RATIO_W-1:0] div_cnt_q [NUM_SETUP];
    logic [SETUP_RATIO_W-1:0] div_cnt_d [NUM_SETUP];
    logic ack_q, ack_d;

    localparam logic [DATA_W-1:0] SETUP_RST [NUM_SETUP] = '{
        SETUP_ADC_RST, SETUP_DAC_RST, SETUP_CONV_RST,
        SETUP_TIMER_RST, SETUP_DSP_RST};
    localparam logic [DATA_W-1:0] PLL_CFG_RST =
        {AUX_ODIV_RST, AUX_NDIV_RST};
    // routing to the reference, output on unless inhibited
    localparam logic [DATA_W-1:0] REF_CFG_RST =
        {1'b0, 1'b0, HAS_RF_SYNTH, AUX_RDIV_RST};
    localparam logic [DATA_W-1:0] CORE_PLL_RST =
        {5'h01, CORE_NDIV_RST};
    localparam logic [DATA_W-1:0] CORE_REF_RST =
        {3'h0, CORE_RDIV_RST};

    // ********************************************************
    // reference input: edge detect and speed check
    // ********************************************************
    assign ref_tick = XTAL_IN & ~xtal_q;

    // reference period measured between rising edges
    always_comb begin
        xtal_d = XTAL_IN;
        rper_cnt_d = rper_cnt_q;
        rper_d = rper_q;
        fast_d = fast_q;
        if (rper_cnt_q != {PER_W{1'b1}}) begin
            rper_cnt_d = rper_cnt_q + 1'b1;
        end
        if (ref_tick) begin
            rper_d = rper_cnt_q + 1'b1;
            rper_cnt_d = '0;
            fast_d = (rper_cnt_q + 1'b1) < PER_W'(REF_MIN_CYC);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            xtal_q <= 1'b0;
            rper_cnt_q <= '0;
            rper_q <= '0;
            fast_q <= 1'b0;
        end else begin
            xtal_q <= xtal_d;
            rper_cnt_q <= rper_cnt_d;
            rper_q <= rper_d;
            fast_q <= fast_d;
        end
    end

    // ********************************************************
    // configure registers and clock setup entries
    // ********************************************************
    // write decode; unmapped writes are dropped and flagged
    always_comb begin
        pll_cfg_d = pll_cfg_q;
        ref_cfg_d = ref_cfg_q;
        core_pll_d = core_pll_q;
        core_ref_d = core_ref_q;
        setup_d = setup_q;
        err_d = 1'b0;
        if (REG_WR) begin
            case (REG_ADDR)
                AUX_A_PLL_CFG_ADDR: pll_cfg_d[0] = REG_WDATA;
                AUX_A_REF_CFG_ADDR: ref_cfg_d[0] = REG_WDATA;
                AUX_B_PLL_CFG_ADDR: pll_cfg_d[1] = REG_WDATA;
                AUX_B_REF_CFG_ADDR: ref_cfg_d[1] = REG_WDATA;
                // written by the loaded firmware only
                CORE_PLL_CFG_ADDR: core_pll_d = REG_WDATA;
                CORE_REF_CFG_ADDR: core_ref_d = REG_WDATA;
                default: err_d = 1'b1;
            endcase
        end
        if (SETUP_WR) begin
            if (SETUP_SEL >= SETUP_FIRST && SETUP_SEL <= SETUP_LAST) begin
                setup_d[3'(SETUP_SEL - SETUP_FIRST)] = SETUP_DATA;
            end else begin
                err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pll_cfg_q <= '{PLL_CFG_RST, PLL_CFG_RST};
            ref_cfg_q <= '{REF_CFG_RST, REF_CFG_RST};
            core_pll_q <= CORE_PLL_RST;
            core_ref_q <= CORE_REF_RST;
            setup_q <= SETUP_RST;
            err_q <= 1'b0;
        end else begin
            pll_cfg_q <= pll_cfg_d;
            ref_cfg_q <= ref_cfg_d;
            core_pll_q <= core_pll_d;
            core_ref_q <= core_ref_d;
            setup_q <= setup_d;
            err_q <= err_d;
        end
    end

    // ********************************************************
    // core clock loop
    // ********************************************************
    // core tick = reference / R * N, output divider fixed at one
    clock_synth_loop #(
        .RDIV_W(RDIV_W),
        .NDIV_W(NDIV_W),
        .ODIV_W(ODIV_W),
        .PER_W(PER_W)
    ) u_core_loop (
        .clk(CLK),
        .rst(RST),
        .ref_tick(ref_tick),
        .run(1'b1),
        .ref_div(core_ref_q[RDIV_LSB +: RDIV_W]),
        .main_div(core_pll_q[NDIV_LSB +: NDIV_W]),
        .out_div(ODIV_W'(1)),
        .clk_out(core_clk),
        .out_tick(core_tick),
        .locked(core_lock)
    );

    // ********************************************************
    // aux clock generators
    // ********************************************************
    for (genvar i = 0; i < 2; i++) begin : g_aux
        assign aux_run[i] = ~ref_cfg_q[i][REF_PSAVE_BIT];
        clock_synth_loop #(
            .RDIV_W(RDIV_W),
            .NDIV_W(NDIV_W),
            .ODIV_W(ODIV_W),
            .PER_W(PER_W)
        ) u_aux_loop (
            .clk(CLK),
            .rst(RST),
            .ref_tick(ref_tick),
            .run(aux_run[i]),
            .ref_div(ref_cfg_q[i][RDIV_LSB +: RDIV_W]),
            .main_div(pll_cfg_q[i][NDIV_LSB +: NDIV_W]),
            .out_div(pll_cfg_q[i][ODIV_LSB +: ODIV_W]),
            .clk_out(aux_clk[i]),
            .out_tick(),
            .locked(aux_lock[i])
        );
    end

    // output selection: powersave or inhibit force low
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            if (!aux_run[k] || !ref_cfg_q[k][REF_OUT_EN_BIT]) begin
                aux_out_d[k] = 1'b0;
            end else if (ref_cfg_q[k][REF_ROUTE_BIT]) begin
                aux_out_d[k] = aux_clk[k];
            end else begin
                aux_out_d[k] = XTAL_IN;
            end
            aux_lock_d[k] = aux_lock[k];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            aux_out_q <= '0;
            aux_lock_q <= '0;
        end else begin
            aux_out_q <= aux_out_d;
            aux_lock_q <= aux_lock_d;
        end
    end

    // ********************************************************
    // tick dividers from reference or core clock
    // ********************************************************
    for (genvar j = 0; j < NUM_SETUP; j++) begin : g_div
        logic src;
        logic [SETUP_RATIO_W-1:0] ratio;
        assign src = setup_q[j][SETUP_SRC_BIT] ? core_tick : ref_tick;
        assign ratio = setup_q[j][SETUP_RATIO_W-1:0];
        // a ratio of 0 behaves as 1
        always_comb begin
            div_cnt_d[j] = div_cnt_q[j];
            div_tick_d[j] = 1'b0;
            if (src) begin
                if (div_cnt_q[j] + 1'b1 >= ratio) begin
                    div_cnt_d[j] = '0;
                    div_tick_d[j] = 1'b1;
                end else begin
                    div_cnt_d[j] = div_cnt_q[j] + 1'b1;
                end
            end
        end
        always_ff @(posedge CLK) begin
            if (RST) begin
                div_cnt_q[j] <= '0;
                div_tick_q[j] <= 1'b0;
            end else begin
                div_cnt_q[j] <= div_cnt_d[j];
                div_tick_q[j] <= div_tick_d[j];
            end
        end
    end

    // ********************************************************
    // bus service latency
    // ********************************************************
    // idle mode waits for the timer tick, otherwise next cycle
    always_comb begin
        ack_d = BUS_REQ & ~ack_q &
            (~IDLE_MODE | div_tick_q[SETUP_TIMER]);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // ********************************************************
    // outputs, each from a flip-flop
    // ********************************************************
    assign BUS_ACK = ack_q;
    assign CORE_CLK_TICK = core_tick;
    assign ADC_SAMPLE_TICK = div_tick_q[SETUP_ADC];
    assign DAC_SAMPLE_TICK = div_tick_q[SETUP_DAC];
    assign CONVERT_TICK = div_tick_q[SETUP_CONV];
    assign GENERAL_PURPOSE_TICK_TIMER = div_tick_q[SETUP_TIMER];
    assign DSP_TICK = div_tick_q[SETUP_DSP];
    assign AUX_CLOCK_OUT_A = aux_out_q[0];
    assign AUX_CLOCK_OUT_B = aux_out_q[1];
    assign AUX_LOCKED = aux_lock_q;
    assign REF_TOO_FAST = fast_q;
    assign REF_PERIOD = rper_q;
    assign REG_ERR = err_q;
endmodule

/* File: tb/aux_clock_sink.sv */
// model of circuits clocked by the aux outputs
`timescale 1ns/1ps
module aux_clock_sink (
    input logic clk,
    input logic clear,
    input logic aux_a,
    input logic aux_b,
    output int edges_a,
    output int edges_b
);
    logic last_a_q = 1'b0;
    logic last_b_q = 1'b0;
    // count rising edges as a clocked load sees them
    always @(posedge clk) begin
        last_a_q <= aux_a;
        last_b_q <= aux_b;
        if (clear) begin
            edges_a <= 0;
            edges_b <= 0;
        end else begin
            edges_a <= edges_a + int'(aux_a === 1'b1 && last_a_q === 1'b0);
            edges_b <= edges_b + int'(aux_b === 1'b1 && last_b_q === 1'b0);
        end
    end
endmodule

/* File: tb/system_clock_generation_sva.sv */
// assertions for system clock generation
`timescale 1ns/1ps
module system_clock_generation_sva
    import clkgen_pkg::*;
#(
    parameter bit HAS_RF_SYNTH = 1'b1
) (
    input logic CLK,
    input logic RST,
    input logic XTAL_IN,
    input logic REG_WR,
    input logic [clkgen_pkg::ADDR_W-1:0] REG_ADDR,
    input logic SETUP_WR,
    input logic [2:0] SETUP_SEL,
    input logic IDLE_MODE,
    input logic BUS_REQ,
    input logic BUS_ACK,
    input logic CORE_CLK_TICK,
    input logic GENERAL_PURPOSE_TICK_TIMER,
    input logic AUX_CLOCK_OUT_A,
    input logic AUX_CLOCK_OUT_B,
    input logic REF_TOO_FAST,
    input logic [clkgen_pkg::PER_W-1:0] REF_PERIOD,
    input logic REG_ERR
);
    logic touched_q, bad_reg, bad_setup;
    // ********************************************************
    // helper logic
    // ********************************************************
    // writes outside the map or the entry range
    assign bad_reg = REG_WR && !(REG_ADDR inside {[AUX_A_PLL_CFG_ADDR:
        AUX_B_REF_CFG_ADDR], CORE_PLL_CFG_ADDR, CORE_REF_CFG_ADDR});
    assign bad_setup = SETUP_WR && (SETUP_SEL < 3'h2 || SETUP_SEL > 3'h6);
    // set by the first register write after reset
    always_ff @(posedge CLK) begin
        touched_q <= RST ? 1'b0 : touched_q | REG_WR;
    end
    // ********************************************************
    // properties
    // ********************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_req_start;
        $rose(BUS_REQ) && !IDLE_MODE;
    endsequence
    sequence s_ack_once;
        BUS_ACK ##1 !BUS_ACK;
    endsequence
    a_ack_busy_fast: assert property (s_req_start |=> s_ack_once)
        else $error("busy ack late");
    a_ack_no_repeat: assert property (BUS_ACK |=> !BUS_ACK)
        else $error("ack held");
    a_ack_idle_tick: assert property (IDLE_MODE && $past(IDLE_MODE)
        && BUS_ACK |-> $past(GENERAL_PURPOSE_TICK_TIMER))
        else $error("idle ack off tick");
    a_err_unmapped: assert property (bad_reg |=> REG_ERR)
        else $error("no error on bad address");
    a_err_setup: assert property (bad_setup |=> REG_ERR)
        else $error("no error on bad entry");
    a_err_quiet: assert property (!bad_reg && !bad_setup |=> !REG_ERR)
        else $error("spurious error");
    a_aux_ref_follow: assert property (HAS_RF_SYNTH && !touched_q
        && !$past(RST) |-> AUX_CLOCK_OUT_A == $past(XTAL_IN)
        && AUX_CLOCK_OUT_B == $past(XTAL_IN))
        else $error("aux not reference");
    a_fast_flag: assert property (REF_TOO_FAST |-> REF_PERIOD < 4)
        else $error("false fast flag");
    a_core_pulse: assert property (CORE_CLK_TICK |=> !CORE_CLK_TICK)
        else $error("core tick held");
endmodule
bind system_clock_generation system_clock_generation_sva
    #(.HAS_RF_SYNTH(HAS_RF_SYNTH)) u_sva (.*);

/* File: tb/tb.sv */
// self-checking bench for system clock generation
`timescale 1ns/1ps
module tb;
    import clkgen_pkg::*;
    localparam int REF_HALF = 10; // 5 MHz reference
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic XTAL_IN = 1'b0;
    logic REG_WR = 1'b0;
    logic [ADDR_W-1:0] REG_ADDR = 8'h00;
    logic [DATA_W-1:0] REG_WDATA = 16'h0000;
    logic SETUP_WR = 1'b0;
    logic [2:0] SETUP_SEL = 3'h0;
    logic [DATA_W-1:0] SETUP_DATA = 16'h0000;
    logic IDLE_MODE = 1'b0;
    logic BUS_REQ = 1'b0;
    logic BUS_ACK, CORE_CLK_TICK, ADC_SAMPLE_TICK, DAC_SAMPLE_TICK;
    logic CONVERT_TICK, GENERAL_PURPOSE_TICK_TIMER, DSP_TICK;
    logic AUX_CLOCK_OUT_A, AUX_CLOCK_OUT_B, REF_TOO_FAST, REG_ERR;
    logic [1:0] AUX_LOCKED;
    logic [PER_W-1:0] REF_PERIOD;
    logic [4:0] ticks;
    logic clr = 1'b0;
    logic err;
    logic [7:0] bad [3] = '{8'h00, 8'h01, 8'h07};
    int miscompares = 0;
    int total_checks = 0;
    int cnt [NUM_SETUP];
    int src [NUM_SETUP] = '{1, 1, 1, 0, 1};
    int ratio [NUM_SETUP] = '{3072, 3072, 48, 1536, 1};
    int core_cnt, edges_a, edges_b, lat;
    int xdiv = 0;
    assign ticks = {DSP_TICK, GENERAL_PURPOSE_TICK_TIMER, CONVERT_TICK,
        DAC_SAMPLE_TICK, ADC_SAMPLE_TICK};
    // ********************************************************
    // clocks, design and far side
    // ********************************************************
    always #5 CLK = ~CLK;
    // reference clock, changed off the sampling edge
    always @(negedge CLK) begin
        xdiv = (xdiv + 1) % REF_HALF;
        if (xdiv == 0) XTAL_IN = ~XTAL_IN;
    end
    system_clock_generation #(.HAS_RF_SYNTH(1'b1)) dut (.*);
    aux_clock_sink u_sink (.clk(CLK), .clear(clr), .aux_a(AUX_CLOCK_OUT_A),
        .aux_b(AUX_CLOCK_OUT_B), .edges_a, .edges_b);
    // counters of the core and divided ticks
    always @(posedge CLK) begin
        if (clr) begin
            core_cnt = 0;
            foreach (cnt[i]) cnt[i] = 0;
        end else begin
            core_cnt += int'(CORE_CLK_TICK === 1'b1);
            foreach (cnt[i]) cnt[i] += int'(ticks[i] === 1'b1);
        end
    end
    // ********************************************************
    // tasks and reference model
    // ********************************************************
    task automatic conclude();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic timed_out(string what);
        miscompares++;
        $display("[FAIL] %0t wait ran out: %s", $time, what);
        conclude();
    endtask
    task automatic check_count(string what, int got, int exp, int tol);
        total_checks++;
        if (got < exp - tol || got > exp + tol) begin
            miscompares++;
            $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask
    task automatic check_bits(string what, logic [PER_W-1:0] got,
        logic [PER_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // expected divided ticks over a window of reference edges
    function automatic int tick_exp(int k, int ref_edges);
        return (src[k] != 0 ? ref_edges * 4 : ref_edges) / ratio[k];
    endfunction
    // open a counting window
    task automatic measure(int cycles);
        @(negedge CLK);
        clr = 1'b1;
        @(negedge CLK);
        clr = 1'b0;
        repeat (cycles) @(negedge CLK);
    endtask
    // one register or entry write; err keeps the error pulse
    task automatic write_word(bit setup, logic [7:0] where,
        logic [15:0] data);
        @(negedge CLK);
        if (setup) begin
            SETUP_WR = 1'b1;
            SETUP_SEL = where[2:0];
            SETUP_DATA = data;
        end else begin
            REG_WR = 1'b1;
            REG_ADDR = where;
            REG_WDATA = data;
        end
        @(posedge CLK);
        #1 err = REG_ERR;
        @(negedge CLK);
        REG_WR = 1'b0;
        SETUP_WR = 1'b0;
        if (setup && where >= 8'h02 && where <= 8'h06) begin
            src[where-2] = int'(data[15]);
            ratio[where-2] = data[14:0] == '0 ? 1 : int'(data[14:0]);
        end
    endtask
    // host request held until answered, dropped right after
    task automatic bus_request(int limit, output int waited);
        @(negedge CLK);
        BUS_REQ = 1'b1;
        waited = -1;
        do begin
            @(posedge CLK);
            #1 waited++;
            if (waited > limit) timed_out("bus answer");
        end while (BUS_ACK !== 1'b1);
        @(negedge CLK);
        BUS_REQ = 1'b0;
    endtask
    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        void'($urandom(32'h2fd59ef4));
        repeat (20) @(negedge CLK);
        RST = 1'b0;
        // defaults, 100 reference edges a window
        measure(2000);
        check_count("core tick", core_cnt, 400, 2);
        foreach (cnt[k]) check_count("tick", cnt[k], tick_exp(k, 100), 1);
        check_count("aux a ref", edges_a, 100, 1);
        check_count("aux b ref", edges_b, 100, 1);
        check_bits("ref period", REF_PERIOD, 20'h14);
        check_bits("ref fast", PER_W'(REF_TOO_FAST), 20'h0);
        $display("test defaults done");
        // reprogram every entry, both tick sources used
        write_word(1, 8'h06, 16'h8002);
        write_word(1, 8'h05, 16'h0008);
        write_word(1, 8'h04, 16'h0005);
        write_word(1, 8'h03, {1'b1, 15'($urandom_range(12, 4))});
        write_word(1, 8'h02, 16'h800A);
        measure(2000);
        foreach (cnt[k]) check_count("tick", cnt[k], tick_exp(k, 100), 1);
        foreach (bad[i]) begin
            write_word(1, bad[i], 16'h0001);
            check_bits("setup err", PER_W'(err), 20'h1);
        end
        write_word(0, 8'hAF, 16'hFFFF);
        check_bits("unmapped err", PER_W'(err), 20'h1);
        $display("test setup done");
        // busy ack next cycle, idle ack on timer tick
        bus_request(2, lat);
        check_count("busy ack", lat, 0, 0);
        IDLE_MODE = 1'b1;
        bus_request(200, lat);
        check_count("idle ack", lat, 81, 81);
        IDLE_MODE = 1'b0;
        $display("test bus done");
        // aux a on its loop, b powersaved; core loop words left alone
        write_word(0, AUX_A_REF_CFG_ADDR, {3'b011, 13'd50});
        write_word(0, AUX_A_PLL_CFG_ADDR, {5'd2, 11'd16});
        check_bits("mapped err", PER_W'(err), 20'h0);
        write_word(0, AUX_B_REF_CFG_ADDR, {3'b101, 13'd64});
        lat = 0;
        while (AUX_LOCKED[0] !== 1'b1) begin
            @(negedge CLK);
            lat++;
            if (lat > 6000) timed_out("aux lock");
        end
        repeat (3000) @(negedge CLK);
        measure(10000);
        check_count("aux a loop", edges_a, 500 * 16 / (50 * 2), 3);
        check_count("aux b saved", edges_b, 0, 0);
        write_word(0, AUX_B_REF_CFG_ADDR, {3'b001, 13'd64});
        measure(2000);
        check_count("aux a loop", edges_a, 100 * 16 / (50 * 2), 2);
        check_count("aux b ref", edges_b, 100, 1);
        $display("test aux done");
        conclude();
    end
endmodule
